//--- hw/gpmc_top.sv
// power-mode controller with bus-idle sleep and conversion schedule
`timescale 1ns/100ps
// Notes on behaviour
// - power-up enters ACTIVE, measuring continuously
// - SLEEP stops measuring, keeps all results
// - bus-low enable: both lines low 2s sleeps
// - bus-low sleep recognised within 2.2 seconds
// - bus-low sleep wakes when either line high
// - undervoltage enable: low cell plus steady bus
// - undervoltage sleep wakes on any line change
// - uv sleep entered high accepts START directly
// - undriven bus keeps device asleep, no measuring
// - voltage result every 440ms, two's complement
// - out-of-range results clamp to max or min
// - temperature result every 440ms, two's complement
module gpmc_top
	import gpmc_pkg::*;
#(
	parameter int TICK_DIV = gpmc_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// two-wire bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// sleep enables and undervoltage comparator
	input wire logic bus_low_sleep_enable_i,
	input wire logic undervoltage_sleep_enable_i,
	input wire logic cell_below_uv_i,
	// conversion front end
	output logic conv_start_o,
	input wire logic conv_done_i,
	input wire logic signed [gpmc_pkg::RAW_W-1:0] volt_raw_i,
	input wire logic signed [gpmc_pkg::RAW_W-1:0] temp_raw_i,
	// results and status
	output logic [gpmc_pkg::RES_W-1:0] voltage_o,
	output logic [gpmc_pkg::RES_W-1:0] temperature_o,
	output logic result_update_o,
	output logic active_o,
	output logic [1:0] sleep_cause_o,
	output logic start_ready_o
);
	import gpmc_pkg::*;

	// clamp a raw code into the result width
	function automatic logic [RES_W-1:0] clamp_res(
		input logic signed [RAW_W-1:0] raw
	);
		logic signed [RAW_W-1:0] lim;
		lim = raw;
		if (raw > RES_MAX)
			lim = RES_MAX;
		else if (raw < RES_MIN)
			lim = RES_MIN;
		return lim[RES_W-1:0];
	endfunction

	logic scl_s;
	logic sda_s;
	logic uv_s;

	// bus pins and comparator cross into the clock domain
	gpmc_sync #(.RESET_VAL(1'b1)) u_sync_scl (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.async_i(scl_i),
		.sync_o(scl_s)
	);
	gpmc_sync #(.RESET_VAL(1'b1)) u_sync_sda (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.async_i(sda_i),
		.sync_o(sda_s)
	);
	gpmc_sync #(.RESET_VAL(1'b0)) u_sync_uv (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.async_i(cell_below_uv_i),
		.sync_o(uv_s)
	);

	gpmc_mode_e mode_q;
	gpmc_mode_e mode_d;
	logic scl_prev_q;
	logic scl_prev_d;
	logic sda_prev_q;
	logic sda_prev_d;
	logic entry_high_q;
	logic entry_high_d;
	logic [TICK_CNT_W-1:0] div_q;
	logic [TICK_CNT_W-1:0] div_d;
	logic tick;
	logic [IDLE_CNT_W-1:0] idle_q;
	logic [IDLE_CNT_W-1:0] idle_d;
	logic [CONV_CNT_W-1:0] conv_cnt_q;
	logic [CONV_CNT_W-1:0] conv_cnt_d;
	logic conv_start_q;
	logic conv_start_d;
	logic [RES_W-1:0] volt_q;
	logic [RES_W-1:0] volt_d;
	logic [RES_W-1:0] temp_q;
	logic [RES_W-1:0] temp_d;
	logic update_q;
	logic update_d;
	logic active_q;
	logic active_d;
	logic [1:0] cause_q;
	logic [1:0] cause_d;
	logic ready_q;
	logic ready_d;
	logic bus_change;
	logic bus_low;
	logic idle_done;

	// line activity and idle conditions
	always_comb
	begin
		bus_change = (scl_s != scl_prev_q) || (sda_s != sda_prev_q);
		bus_low = !scl_s && !sda_s;
		idle_done = (idle_q >= IDLE_CNT_W'(SLEEP_TICKS));
	end

	// internal time base, one tick per ms, gated off in sleep
	always_comb
	begin
		div_d = div_q;
		tick = 1'b0;
		if (mode_q != GPMC_ACTIVE)
			div_d = '0;
		else if (div_q == TICK_CNT_W'(TICK_DIV - 1))
		begin
			div_d = '0;
			tick = 1'b1;
		end
		else
			div_d = div_q + 1'b1;
	end

	// power mode sequencing
	always_comb
	begin
		mode_d = mode_q;
		entry_high_d = entry_high_q;
		scl_prev_d = scl_s;
		sda_prev_d = sda_s;
		case (mode_q)
			GPMC_ACTIVE:
			begin
				if (bus_low_sleep_enable_i && bus_low && idle_done)
					mode_d = GPMC_SLEEP_BUS_LOW;
				else if (undervoltage_sleep_enable_i && uv_s && idle_done)
				begin
					mode_d = GPMC_SLEEP_UV;
					entry_high_d = scl_s && sda_s;
				end
			end
			GPMC_SLEEP_BUS_LOW:
			begin
				// a bus nobody drives leaves the device asleep
				if (scl_s || sda_s)
					mode_d = GPMC_ACTIVE;
			end
			GPMC_SLEEP_UV:
			begin
				if (bus_change)
					mode_d = GPMC_ACTIVE;
			end
			default:
				mode_d = GPMC_ACTIVE;
		endcase
	end

	// bus-idle timer, restarted by any line change
	always_comb
	begin
		idle_d = idle_q;
		if (mode_q != GPMC_ACTIVE || bus_change)
			idle_d = '0;
		else if (tick && !idle_done)
			idle_d = idle_q + 1'b1;
	end

	// conversion schedule and result capture
	always_comb
	begin
		conv_cnt_d = conv_cnt_q;
		conv_start_d = 1'b0;
		volt_d = volt_q;
		temp_d = temp_q;
		update_d = 1'b0;
		if (mode_q != GPMC_ACTIVE)
			conv_cnt_d = '0;
		else
		begin
			if (tick)
			begin
				if (conv_cnt_q == CONV_CNT_W'(CONV_TICKS - 1))
				begin
					conv_cnt_d = '0;
					// no request on the cycle that enters sleep
					conv_start_d = active_d;
				end
				else
					conv_cnt_d = conv_cnt_q + 1'b1;
			end
			if (conv_done_i)
			begin
				volt_d = clamp_res(volt_raw_i);
				temp_d = clamp_res(temp_raw_i);
				update_d = 1'b1;
			end
		end
	end

	// status seen outside
	always_comb
	begin
		active_d = (mode_d == GPMC_ACTIVE);
		cause_d = CAUSE_NONE;
		if (mode_d == GPMC_SLEEP_BUS_LOW)
			cause_d = CAUSE_BUS_LOW;
		else if (mode_d == GPMC_SLEEP_UV)
			cause_d = CAUSE_UV;
		// a START is only seen once the bus stands high
		ready_d = active_d
			|| (mode_d == GPMC_SLEEP_UV && entry_high_d);
	end

	// register all state
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			mode_q <= GPMC_ACTIVE;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			entry_high_q <= 1'b0;
			div_q <= '0;
			idle_q <= '0;
			conv_cnt_q <= '0;
			conv_start_q <= 1'b0;
			volt_q <= VOLT_RESET;
			temp_q <= TEMP_RESET;
			update_q <= 1'b0;
			active_q <= 1'b1;
			cause_q <= CAUSE_NONE;
			ready_q <= 1'b1;
		end
		else
		begin
			mode_q <= mode_d;
			scl_prev_q <= scl_prev_d;
			sda_prev_q <= sda_prev_d;
			entry_high_q <= entry_high_d;
			div_q <= div_d;
			idle_q <= idle_d;
			conv_cnt_q <= conv_cnt_d;
			conv_start_q <= conv_start_d;
			volt_q <= volt_d;
			temp_q <= temp_d;
			update_q <= update_d;
			active_q <= active_d;
			cause_q <= cause_d;
			ready_q <= ready_d;
		end
	end

	// outputs straight from flops; sda is never driven here
	assign sda_o = 1'b0;
	assign sda_oe_o = 1'b0;
	assign conv_start_o = conv_start_q;
	assign voltage_o = volt_q;
	assign temperature_o = temp_q;
	assign result_update_o = update_q;
	assign active_o = active_q;
	assign sleep_cause_o = cause_q;
	assign start_ready_o = ready_q;

endmodule

//--- hw/gpmc_pkg.sv
// constants and types of the gauge power-mode controller
package gpmc_pkg;

	// clock and time base
	localparam int CLK_PERIOD_NS = 40;
	localparam int TIME_BASE_NS = 1000000;
	localparam int TICK_CYCLES = TIME_BASE_NS / CLK_PERIOD_NS;
	localparam int TICK_CNT_W = 15;

	// bus-idle sleep time and conversion period, in ms ticks
	localparam int SLEEP_TIME_MS = 2000;
	localparam int SLEEP_TICKS = SLEEP_TIME_MS * 1000000 / TIME_BASE_NS;
	localparam int CONV_PERIOD_MS = 440;
	localparam int CONV_TICKS = CONV_PERIOD_MS * 1000000 / TIME_BASE_NS;
	localparam int IDLE_CNT_W = 12;
	localparam int CONV_CNT_W = 9;

	// raw front-end and result widths
	localparam int RAW_W = 16;
	localparam int RES_W = 11;
	localparam logic signed [RAW_W-1:0] RES_MAX = 16'sh03ff;
	localparam logic signed [RAW_W-1:0] RES_MIN = -16'sh0400;

	// reset values of the result registers
	localparam logic [RES_W-1:0] VOLT_RESET = 11'h000;
	localparam logic [RES_W-1:0] TEMP_RESET = 11'h000;

	// sleep cause codes
	localparam logic [1:0] CAUSE_NONE = 2'h0;
	localparam logic [1:0] CAUSE_BUS_LOW = 2'h1;
	localparam logic [1:0] CAUSE_UV = 2'h2;

	// power modes
	typedef enum logic [1:0] {
		GPMC_ACTIVE,
		GPMC_SLEEP_BUS_LOW,
		GPMC_SLEEP_UV
	} gpmc_mode_e;

endpackage

//--- hw/gpmc_sync.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module gpmc_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// level in and out
	input wire logic async_i,
	output logic sync_o
);

	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	// first flop feeds only the second
	always_comb
	begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	// register both stages
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;

endmodule

//--- bench/gpmc_top_chk.sv
// port assertions for the power-mode controller
`timescale 1ns/100ps
module gpmc_top_chk
	import gpmc_pkg::*;
(
	// clock, reset and bus pins
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	// conversion path
	input wire logic conv_start_o,
	input wire logic conv_done_i,
	input wire logic signed [gpmc_pkg::RAW_W-1:0] volt_raw_i,
	input wire logic signed [gpmc_pkg::RAW_W-1:0] temp_raw_i,
	input wire logic [gpmc_pkg::RES_W-1:0] voltage_o,
	input wire logic [gpmc_pkg::RES_W-1:0] temperature_o,
	input wire logic result_update_o,
	// mode status
	input wire logic active_o,
	input wire logic [1:0] sleep_cause_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (srst_i);
	// mode entry, sleep and wake
	a_reset_active: assert property (
		$fell(srst_i) |-> active_o && sleep_cause_o == CAUSE_NONE)
		else $error("not active after reset");
	a_sleep_cause: assert property (
		$fell(active_o) |-> sleep_cause_o != CAUSE_NONE)
		else $error("sleep without cause");
	a_sleep_no_conv: assert property (
		!active_o |-> !conv_start_o)
		else $error("conversion started asleep");
	a_sleep_holds: assert property (
		!active_o [*3] |-> $stable(voltage_o) && $stable(temperature_o))
		else $error("result changed asleep");
	a_wake_bus_low: assert property (
		sleep_cause_o == CAUSE_BUS_LOW && $rose(scl_i | sda_i)
		|-> ##[1:5] active_o)
		else $error("no wake on high line");
	a_wake_uv: assert property (
		sleep_cause_o == CAUSE_UV && ($changed(scl_i) || $changed(sda_i))
		|-> ##[1:5] active_o)
		else $error("no wake on line change");
	// results follow conversions
	a_done_update: assert property (
		conv_done_i && active_o |=> result_update_o)
		else $error("no update after done");
	a_clamp_high: assert property (
		conv_done_i && volt_raw_i > RES_MAX && active_o
		|=> voltage_o == 11'h3ff)
		else $error("voltage not clamped high");
	a_clamp_low: assert property (
		conv_done_i && temp_raw_i < RES_MIN && active_o
		|=> temperature_o == 11'h400)
		else $error("temperature not clamped low");
endmodule

//--- bench/gpmc_host_model.sv
// two-wire host: link clock in frames, pull-down when absent
`timescale 1ns/100ps
module gpmc_host_model (
	// host controls
	input wire logic frame_i,
	input wire logic bus_high_i,
	// bus lines
	output logic scl_o,
	output logic sda_o
);
	// 320 ns clock, equal 160 ns high and low phases, still outside frames
	initial
	begin
		scl_o = 1'b1;
		#7;
		forever
		begin
			scl_o = frame_i ? ~scl_o : bus_high_i;
			#160;
		end
	end
	// data falls with clock high: start of a transaction
	assign sda_o = frame_i ? 1'b0 : bus_high_i;
endmodule

//--- bench/gpmc_top_bench.sv
// bench for the power-mode controller
`timescale 1ns/100ps
module gpmc_top_bench;
	import gpmc_pkg::*;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic bl_en = 1'b0;
	logic uv_en = 1'b0;
	logic cell_low = 1'b0;
	logic done = 1'b0;
	logic signed [RAW_W-1:0] vraw = 16'h0000;
	logic signed [RAW_W-1:0] traw = 16'h0000;
	logic frame = 1'b0;
	logic bus_high = 1'b1;
	logic scl, sda, sda_o, sda_oe_o, conv_start_o, result_update_o;
	logic active_o, start_ready_o;
	logic [1:0] sleep_cause_o;
	logic [RES_W-1:0] voltage_o, temperature_o;
	wire sda_line;
	int num_errors = 0;
	int checks = 0;
	int n;
	// clock, and the shared data wire
	always #20 clock_i = ~clock_i;
	assign sda_line = sda_oe_o ? sda_o : sda;
	gpmc_host_model gpmc_host_model_inst (.frame_i(frame),
		.bus_high_i(bus_high), .scl_o(scl), .sda_o(sda));
	gpmc_top #(.TICK_DIV(4)) gpmc_top_inst (.clock_i(clock_i),
		.srst_i(srst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .bus_low_sleep_enable_i(bl_en),
		.undervoltage_sleep_enable_i(uv_en), .cell_below_uv_i(cell_low),
		.conv_start_o(conv_start_o), .conv_done_i(done),
		.volt_raw_i(vraw), .temp_raw_i(traw), .voltage_o(voltage_o),
		.temperature_o(temperature_o), .result_update_o(result_update_o),
		.active_o(active_o), .sleep_cause_o(sleep_cause_o),
		.start_ready_o(start_ready_o));
	// compare helpers
	task automatic cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic cmp_val(input logic [10:0] got, input logic [10:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_mode(input logic want, input int lim);
		n = 0;
		while (active_o !== want && n < lim)
		begin
			@(posedge clock_i);
			#1;
			n++;
		end
		cmp_bit(active_o, want);
	endtask
	// answer one conversion request and check the results
	task automatic convert(input logic [15:0] v, input logic [15:0] t,
		input logic [10:0] ev, input logic [10:0] et);
		wait (conv_start_o === 1'b1);
		@(posedge clock_i);
		done <= 1'b1;
		vraw <= v;
		traw <= t;
		@(posedge clock_i);
		done <= 1'b0;
		#1;
		cmp_bit(result_update_o, 1'b1);
		cmp_val(voltage_o, ev);
		cmp_val(temperature_o, et);
	endtask
	// bus lost: refused while disabled, then sleep and wake
	task automatic bus_low_sleep();
		@(posedge clock_i);
		bus_high <= 1'b0;
		repeat (8400) @(posedge clock_i);
		#1;
		cmp_bit(active_o, 1'b1);
		// raise the bus first so the stale idle count restarts
		@(posedge clock_i);
		bus_high <= 1'b1;
		repeat (8) @(posedge clock_i);
		bl_en <= 1'b1;
		repeat (4) @(posedge clock_i);
		bus_high <= 1'b0;
		wait_mode(1'b0, 9000);
		cmp_bit(n >= 7990 && n <= 8800, 1'b1);
		cmp_val({9'h000, sleep_cause_o}, 11'h001);
		cmp_bit(start_ready_o, 1'b0);
		@(posedge clock_i);
		done <= 1'b1;
		@(posedge clock_i);
		done <= 1'b0;
		repeat (2000) @(posedge clock_i);
		#1;
		cmp_bit(active_o, 1'b0);
		cmp_val(voltage_o, 11'h123);
		@(posedge clock_i);
		bus_high <= 1'b1;
		wait_mode(1'b1, 12);
		cmp_val(voltage_o, 11'h123);
		convert(16'h0050, 16'h00c8, 11'h050, 11'h0c8);
	endtask
	// low cell with bus high, then a host frame wakes it
	task automatic uv_sleep();
		@(posedge clock_i);
		bl_en <= 1'b0;
		uv_en <= 1'b1;
		cell_low <= 1'b1;
		wait_mode(1'b0, 9000);
		cmp_val({9'h000, sleep_cause_o}, 11'h002);
		cmp_bit(start_ready_o, 1'b1);
		@(posedge clock_i);
		frame <= 1'b1;
		wait_mode(1'b1, 12);
		repeat (9000) @(posedge clock_i);
		#1;
		cmp_bit(active_o, 1'b1);
		@(posedge clock_i);
		frame <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (5) @(posedge clock_i);
		srst_i <= 1'b0;
		@(posedge clock_i);
		#1;
		cmp_bit(active_o, 1'b1);
		cmp_val({9'h000, sleep_cause_o}, 11'h000);
		cmp_val(voltage_o, VOLT_RESET);
		cmp_bit(sda_oe_o, 1'b0);
		convert(16'h0500, 16'hfb00, 11'h3ff, 11'h400);
		convert(16'h0123, 16'hfff8, 11'h123, 11'h7f8);
		bus_low_sleep();
		uv_sleep();
		report_and_stop();
	end
	// watchdog against a hang
	initial
	begin
		repeat (60000) @(posedge clock_i);
		num_errors++;
		report_and_stop();
	end
endmodule
bind gpmc_top gpmc_top_chk gpmc_top_chk_inst (.clock_i(clock_i),
	.srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i),
	.conv_start_o(conv_start_o), .conv_done_i(conv_done_i),
	.volt_raw_i(volt_raw_i), .temp_raw_i(temp_raw_i),
	.voltage_o(voltage_o), .temperature_o(temperature_o),
	.result_update_o(result_update_o), .active_o(active_o),
	.sleep_cause_o(sleep_cause_o));
